//--- display_cfg_pkg.sv
/*
  Package for the display configuration command logic: command codes,
  command range limits, field positions, reset values and the codes used
  by the colour expansion setting.
  Assumes a single 200 MHz clock domain and byte-wide command traffic.
*/
`default_nettype none
package display_cfg_pkg;

  // =====================================================================
  // command codes and protection ranges
  localparam logic [7:0] CMD_PROTECT        = 8'hb0;
  localparam logic [7:0] CMD_STANDBY        = 8'hb1;
  localparam logic [7:0] CMD_FMEM_IF        = 8'hb3;
  localparam logic [7:0] USER_RANGE_LAST    = 8'haf;
  localparam logic [7:0] MFR_LOW_FIRST      = 8'hb1;
  localparam logic [7:0] MFR_MID_FIRST      = 8'he0;
  localparam logic [7:0] MFR_HIGH_FIRST     = 8'hf0;

  // =====================================================================
  // protection levels
  localparam logic [1:0] PROTECT_LEVEL_HIGH = 2'h1;
  localparam logic [1:0] PROTECT_LEVEL_MID  = 2'h2;
  localparam logic [1:0] PROTECT_LEVEL_ALL  = 2'h3;

  // =====================================================================
  // field positions inside parameter bytes
  localparam int PROTECT_LEVEL_LSB  = 0;
  localparam int STANDBY_BIT        = 0;
  localparam int WRAP_BIT           = 1;
  localparam int TEAR_LSB           = 0;
  localparam int RGB_CYCLE_LSB      = 0;
  localparam int EXPAND_LSB         = 4;
  localparam int DATA_FORMAT_BIT    = 0;
  localparam logic [2:0] FMEM_IF_PARAMS = 3'h4;

  // =====================================================================
  // reset values
  localparam logic [1:0] PROTECT_LEVEL_RST  = 2'h0;
  localparam logic       STANDBY_RST        = 1'b0;
  localparam logic       WRAP_RST           = 1'b0;
  localparam logic [2:0] TEAR_RST           = 3'h0;
  localparam logic [2:0] RGB_CYCLE_RST      = 3'h0;
  localparam logic [1:0] EXPAND_RST         = 2'h0;
  localparam logic       DATA_FORMAT_RST    = 1'b0;

  // =====================================================================
  // colour expansion codes
  localparam logic [1:0] EXPAND_ZERO_LSB    = 2'h0;
  localparam logic [1:0] EXPAND_ONE_LSB     = 2'h1;
  localparam logic [1:0] EXPAND_MSB_LSB     = 2'h2;
  localparam logic [4:0] CHAN5_ALL_ONES     = 5'h1f;
  localparam logic [4:0] CHAN5_ALL_ZERO     = 5'h00;
  localparam logic [5:0] CHAN6_ALL_ONES     = 6'h3f;
  localparam logic [5:0] CHAN6_ALL_ZERO     = 6'h00;

endpackage
`default_nettype wire

//--- color_expand_channel.sv
/*
  One colour channel widener: 5-bit red or blue sample to 6 bits under
  the selected expansion format. Purely combinational; the caller
  registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module color_expand_channel
  import display_cfg_pkg::*;
(
  input  wire logic [1:0] expand_format,
  input  wire logic [4:0] chan_in,
  output logic      [5:0] chan_out
);

  // =====================================================================
  // expansion select
  always_comb begin
    case (expand_format)
      EXPAND_ZERO_LSB: begin
        if (chan_in == CHAN5_ALL_ONES) begin
          chan_out = CHAN6_ALL_ONES;
        end else begin
          chan_out = {chan_in, 1'b0};
        end
      end
      EXPAND_ONE_LSB: begin
        if (chan_in == CHAN5_ALL_ZERO) begin
          chan_out = CHAN6_ALL_ZERO;
        end else begin
          chan_out = {chan_in, 1'b1};
        end
      end
      EXPAND_MSB_LSB: chan_out = {chan_in, chan_in[4]};
      // code 11 is disabled; treat like a zero fill without the exception
      default: chan_out = {chan_in, 1'b0};
    endcase
  end

endmodule // color_expand_channel
`default_nettype wire

//--- display_cmd_protect_config.sv
/*
  Configuration command logic of a display driver: command access
  protection, deep standby request and frame memory access / interface
  settings, with the write window counter, tearing pulse divider, RGB
  write cycle divider and 16-to-18-bit colour expansion they steer.
  Assumes the host bus pins are already synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module display_cmd_protect_config
  import display_cfg_pkg::*;
#(
  parameter int COORD_W = 9
)(
  input  wire logic               clock,
  input  wire logic               arst_n,
  // host command bus
  input  wire logic               chip_select_n,
  input  wire logic               data_command_select,
  input  wire logic               write_strobe_n,
  input  wire logic [7:0]         bus_data,
  input  wire logic               bus_is_16bit_or_serial,
  input  wire logic               standby_exit,
  // window and frame timing
  input  wire logic [COORD_W-1:0] window_col_start,
  input  wire logic [COORD_W-1:0] window_col_end,
  input  wire logic [COORD_W-1:0] window_page_start,
  input  wire logic [COORD_W-1:0] window_page_end,
  input  wire logic               window_restart,
  input  wire logic               frame_start,
  // pixel stream
  input  wire logic               pixel_in_valid,
  input  wire logic [15:0]        pixel_in,
  output logic                    pixel_out_valid,
  output logic [17:0]             pixel_out,
  output logic [COORD_W-1:0]      pixel_col,
  output logic [COORD_W-1:0]      pixel_page,
  // settings and status
  output logic [1:0]              cmd_protect_level,
  output logic                    standby_request,
  output logic                    logic_supply_off,
  output logic                    config_valid,
  output logic                    write_wrap_enable,
  output logic [2:0]              tear_interval,
  output logic [2:0]              rgb_write_cycle,
  output logic [1:0]              color_expand_format,
  output logic                    bus_data_format,
  output logic                    bus_data_format_active,
  output logic                    cmd_rejected,
  output logic                    tear_signal,
  output logic                    rgb_frame_write_en
);

  // =====================================================================
  // elaboration check
  generate
    if (COORD_W < 2 || COORD_W > 16) begin : g_bad_width
      $error("COORD_W must be between 2 and 16");
    end
  endgenerate

  // =====================================================================
  // command decoder state
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_PROTECT = 4'b0010,
    ST_STANDBY = 4'b0100,
    ST_FMEM_IF = 4'b1000
  } decode_state_t;

  decode_state_t decode_q;
  decode_state_t decode_d;
  logic          strobe_q;
  logic          write_taken;
  logic          cmd_write;
  logic          param_write;
  logic          cmd_allowed;
  logic [2:0]    param_idx_q;
  logic [1:0]    protect_q;
  logic          standby_q;
  logic          valid_q;
  logic          wrap_q;
  logic [2:0]    tear_q;
  logic [2:0]    rgb_cycle_q;
  logic [1:0]    expand_q;
  logic          format_q;
  logic          rejected_q;

  // write edge: bytes are taken on the rising edge of the write strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= write_strobe_n;
    end
  end

  assign write_taken = write_strobe_n && !strobe_q && !chip_select_n;
  assign cmd_write   = write_taken && !data_command_select;
  assign param_write = write_taken && data_command_select;

  // protection filter on the incoming command code
  always_comb begin
    if (bus_data <= USER_RANGE_LAST || bus_data == CMD_PROTECT) begin
      cmd_allowed = 1'b1;
    end else if (bus_data >= MFR_HIGH_FIRST) begin
      cmd_allowed = (protect_q < PROTECT_LEVEL_HIGH);
    end else if (bus_data >= MFR_MID_FIRST) begin
      cmd_allowed = (protect_q < PROTECT_LEVEL_MID);
    end else if (bus_data >= MFR_LOW_FIRST) begin
      cmd_allowed = (protect_q < PROTECT_LEVEL_ALL);
    end else begin
      cmd_allowed = 1'b1;
    end
  end

  // next decode state; no power state gates decoding
  always_comb begin
    decode_d = decode_q;
    if (cmd_write) begin
      if (!cmd_allowed) begin
        decode_d = ST_IDLE;
      end else begin
        case (bus_data)
          CMD_PROTECT: decode_d = ST_PROTECT;
          CMD_STANDBY: decode_d = ST_STANDBY;
          CMD_FMEM_IF: decode_d = ST_FMEM_IF;
          default:     decode_d = ST_IDLE;
        endcase
      end
    end else if (param_write) begin
      case (decode_q)
        ST_PROTECT: decode_d = ST_IDLE;
        ST_STANDBY: decode_d = ST_IDLE;
        ST_FMEM_IF: begin
          if (param_idx_q == FMEM_IF_PARAMS - 3'h1) begin
            decode_d = ST_IDLE;
          end
        end
        default: decode_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      decode_q <= ST_IDLE;
    end else begin
      decode_q <= decode_d;
    end
  end

  // parameter index restarts with every command byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      param_idx_q <= 3'h0;
    end else if (cmd_write) begin
      param_idx_q <= 3'h0;
    end else if (param_write && decode_q == ST_FMEM_IF) begin
      param_idx_q <= param_idx_q + 3'h1;
    end
  end

  // one-cycle flag for a blocked command byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rejected_q <= 1'b0;
    end else begin
      rejected_q <= cmd_write && !cmd_allowed;
    end
  end

  // =====================================================================
  // stored settings
  // besides standby_exit on the standby request and standby on config_valid, only arst_n clears these; a software reset command never reaches here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      protect_q <= PROTECT_LEVEL_RST;
    end else if (param_write && decode_q == ST_PROTECT) begin
      protect_q <= bus_data[PROTECT_LEVEL_LSB +: 2];
    end
  end

  // standby request: set or cleared by the parameter bit, otherwise cleared by a wake event
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      standby_q <= STANDBY_RST;
    end else if (param_write && decode_q == ST_STANDBY) begin
      standby_q <= bus_data[STANDBY_BIT];
    end else if (standby_exit) begin
      standby_q <= 1'b0;
    end
  end

  // settings are marked stale once standby drops the logic supply
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= 1'b1;
    end else if (standby_q) begin
      valid_q <= 1'b0;
    end else if (param_write && decode_q == ST_FMEM_IF &&
                 param_idx_q == FMEM_IF_PARAMS - 3'h1) begin
      valid_q <= 1'b1;
    end
  end

  // frame memory access and interface parameters, one byte each
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrap_q      <= WRAP_RST;
      tear_q      <= TEAR_RST;
      rgb_cycle_q <= RGB_CYCLE_RST;
      expand_q    <= EXPAND_RST;
      format_q    <= DATA_FORMAT_RST;
    end else if (param_write && decode_q == ST_FMEM_IF) begin
      case (param_idx_q)
        3'h0: wrap_q      <= bus_data[WRAP_BIT];
        3'h1: tear_q      <= bus_data[TEAR_LSB +: 3];
        3'h2: rgb_cycle_q <= bus_data[RGB_CYCLE_LSB +: 3];
        3'h3: begin
          expand_q <= bus_data[EXPAND_LSB +: 2];
          format_q <= bus_data[DATA_FORMAT_BIT];
        end
        default: wrap_q <= wrap_q;
      endcase
    end
  end

  // =====================================================================
  // tearing pulse divider
  // interval is code plus one frames; the odd-step legal codes map exactly
  logic [2:0] tear_cnt_q;
  logic       tear_q_out;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tear_cnt_q <= 3'h0;
      tear_q_out <= 1'b0;
    end else if (frame_start) begin
      if (tear_cnt_q >= tear_q) begin
        tear_cnt_q <= 3'h0;
        tear_q_out <= 1'b1;
      end else begin
        tear_cnt_q <= tear_cnt_q + 3'h1;
        tear_q_out <= 1'b0;
      end
    end else begin
      tear_q_out <= 1'b0;
    end
  end

  // =====================================================================
  // rgb port write cycle divider: write enable holds for a whole frame
  logic [2:0] rgb_cnt_q;
  logic       rgb_en_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rgb_cnt_q <= 3'h0;
      rgb_en_q  <= 1'b0;
    end else if (frame_start) begin
      if (rgb_cnt_q >= rgb_cycle_q) begin
        rgb_cnt_q <= 3'h0;
        rgb_en_q  <= 1'b1;
      end else begin
        rgb_cnt_q <= rgb_cnt_q + 3'h1;
        rgb_en_q  <= 1'b0;
      end
    end
  end

  // =====================================================================
  // write window pointers
  logic [COORD_W-1:0] col_q;
  logic [COORD_W-1:0] page_q;
  logic               window_done_q;
  logic               last_col;
  logic               last_page;
  logic               pixel_take;

  assign last_col   = (col_q == window_col_end);
  assign last_page  = (page_q == window_page_end);
  assign pixel_take = pixel_in_valid && !window_done_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      col_q         <= '0;
      page_q        <= '0;
      window_done_q <= 1'b0;
    end else if (window_restart) begin
      col_q         <= window_col_start;
      page_q        <= window_page_start;
      window_done_q <= 1'b0;
    end else if (pixel_take) begin
      if (last_col && last_page) begin
        col_q  <= window_col_start;
        page_q <= window_page_start;
        // without wrap every later pixel is dropped until restart
        window_done_q <= !wrap_q;
      end else if (last_col) begin
        col_q  <= window_col_start;
        page_q <= page_q + 1'b1;
      end else begin
        col_q <= col_q + 1'b1;
      end
    end
  end

  // =====================================================================
  // colour expansion and pixel output register
  logic [5:0] red_wide;
  logic [5:0] blue_wide;

  color_expand_channel u_red (
    .expand_format (expand_q),
    .chan_in       (pixel_in[15:11]),
    .chan_out      (red_wide)
  );

  color_expand_channel u_blue (
    .expand_format (expand_q),
    .chan_in       (pixel_in[4:0]),
    .chan_out      (blue_wide)
  );

  // discarded pixels never raise the valid output
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pixel_out_valid <= 1'b0;
      pixel_out       <= 18'h00000;
      pixel_col       <= '0;
      pixel_page      <= '0;
    end else begin
      pixel_out_valid <= pixel_take && !window_restart;
      if (pixel_take) begin
        pixel_out  <= {red_wide, pixel_in[10:5], blue_wide};
        pixel_col  <= col_q;
        pixel_page <= page_q;
      end
    end
  end

  // =====================================================================
  // settings and status outputs
  assign cmd_protect_level      = protect_q;
  assign standby_request        = standby_q;
  assign logic_supply_off       = standby_q;
  assign config_valid           = valid_q;
  assign write_wrap_enable      = wrap_q;
  assign tear_interval          = tear_q;
  assign rgb_write_cycle        = rgb_cycle_q;
  assign color_expand_format    = expand_q;
  assign bus_data_format        = format_q;
  assign bus_data_format_active = format_q && bus_is_16bit_or_serial;
  assign cmd_rejected           = rejected_q;
  assign tear_signal            = tear_q_out;
  assign rgb_frame_write_en     = rgb_en_q;

endmodule // display_cmd_protect_config
`default_nettype wire

//--- display_cmd_protect_config_asserts.sv
/*
  Checker for display_cmd_protect_config: command protection, standby, pixel expansion and frame dividers.
  Assumes one clock domain; bound to every instance of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module display_cmd_protect_config_asserts
  import display_cfg_pkg::*;
(
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        chip_select_n,
  input wire logic        data_command_select,
  input wire logic        write_strobe_n,
  input wire logic [7:0]  bus_data,
  input wire logic        bus_is_16bit_or_serial,
  input wire logic        frame_start,
  input wire logic        pixel_in_valid,
  input wire logic [15:0] pixel_in,
  input wire logic        pixel_out_valid,
  input wire logic [17:0] pixel_out,
  input wire logic [1:0]  cmd_protect_level,
  input wire logic        standby_request,
  input wire logic        logic_supply_off,
  input wire logic        config_valid,
  input wire logic [1:0]  color_expand_format,
  input wire logic        bus_data_format,
  input wire logic        bus_data_format_active,
  input wire logic        cmd_rejected,
  input wire logic        tear_signal,
  input wire logic        rgb_frame_write_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // =====================================================================
  // helpers
  logic strobe_q;
  logic take;
  // strobe history starts high so a held strobe makes no byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) strobe_q <= 1'b1;
    else strobe_q <= write_strobe_n;
  end
  assign take = !chip_select_n && write_strobe_n && !strobe_q;
  function automatic logic blocked(input logic [7:0] c, input logic [1:0] lv);
    return (lv == 2'h3 && c >= MFR_LOW_FIRST && c < MFR_MID_FIRST) || (lv >= 2'h2 && c[7:4] == 4'he)
      || (lv != 2'h0 && c[7:4] == 4'hf);
  endfunction
  function automatic logic [5:0] exp6(input logic [1:0] f, input logic [4:0] c);
    case (f)
      EXPAND_ONE_LSB: return (c == CHAN5_ALL_ZERO) ? CHAN6_ALL_ZERO : {c, 1'b1};
      EXPAND_MSB_LSB: return {c, c[4]};
      default: return (c == CHAN5_ALL_ONES) ? CHAN6_ALL_ONES : {c, 1'b0};
    endcase
  endfunction
  sequence s_cmd_taken;
    take && !data_command_select;
  endsequence
  property p_expand(logic [1:0] code);
    pixel_out_valid && ($past(color_expand_format) == code) |->
      pixel_out[17:12] == exp6(code, $past(pixel_in[15:11])) && pixel_out[5:0] == exp6(code, $past(pixel_in[4:0]));
  endproperty
  // =====================================================================
  // assertions
  a_blocked_cmd_rejects: assert property (s_cmd_taken ##0 blocked(bus_data, cmd_protect_level) |-> ##[1:2] cmd_rejected)
    else $error("blocked command not rejected");
  a_user_cmd_accepted: assert property (s_cmd_taken ##0 (bus_data <= CMD_PROTECT) |=> !cmd_rejected [*2])
    else $error("user or protect command rejected");
  a_level_on_write: assert property (cmd_protect_level != $past(cmd_protect_level) |-> $past(take && data_command_select))
    else $error("protection level changed without a parameter write");
  a_supply_tracks_req: assert property (logic_supply_off == standby_request || logic_supply_off == $past(standby_request))
    else $error("supply off differs from standby request");
  a_standby_invalidates: assert property ($rose(standby_request) |-> ##[0:1] !config_valid)
    else $error("settings still valid in standby");
  a_format_active_and: assert property (bus_data_format_active == (bus_data_format && bus_is_16bit_or_serial))
    else $error("format active wrong");
  a_pixel_follows_in: assert property (pixel_out_valid |-> $past(pixel_in_valid))
    else $error("pixel out without pixel in");
  a_expand_zero_fill: assert property (p_expand(EXPAND_ZERO_LSB))
    else $error("zero fill expansion wrong");
  a_expand_one_fill: assert property (p_expand(EXPAND_ONE_LSB))
    else $error("one fill expansion wrong");
  a_expand_msb_fill: assert property (p_expand(EXPAND_MSB_LSB))
    else $error("msb fill expansion wrong");
  a_green_passes: assert property (pixel_out_valid |-> pixel_out[11:6] == $past(pixel_in[10:5]))
    else $error("green changed");
  a_tear_on_frame: assert property (tear_signal |-> $past(frame_start))
    else $error("tear pulse without frame start");
  a_rgb_on_frame: assert property ($changed(rgb_frame_write_en) |-> $past(frame_start))
    else $error("rgb write enable moved off frame start");
endmodule // display_cmd_protect_config_asserts
bind display_cmd_protect_config display_cmd_protect_config_asserts u_asserts (.*);
`default_nettype wire

//--- host_bus_model.sv
/*
  Host processor model on the command bus: sends command and parameter bytes.
  Assumes the caller's clock; bytes are launched on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic  clock,
  output logic       chip_select_n,
  output logic       data_command_select,
  output logic       write_strobe_n,
  output logic [7:0] bus_data
);
  // idle bus: deselected, strobe high
  initial begin
    chip_select_n = 1'b1;
    data_command_select = 1'b0;
    write_strobe_n = 1'b1;
    bus_data = 8'h00;
  end
  // one byte: low strobe, rising strobe takes it, then released bus shows the inverse
  task automatic send(input logic dcs, input logic [7:0] b);
    @(negedge clock);
    chip_select_n = 1'b0;
    data_command_select = dcs;
    bus_data = b;
    write_strobe_n = 1'b0;
    @(negedge clock);
    write_strobe_n = 1'b1;
    @(negedge clock);
    chip_select_n = 1'b1;
    bus_data = ~b;
  endtask
  // command byte then n parameter bytes, first one in the top byte of p
  task automatic write_cmd(input logic [7:0] c, input logic [31:0] p, input int n);
    send(1'b0, c);
    for (int k = 0; k < n; k++) send(1'b1, p[31-8*k -: 8]);
  endtask
endmodule // host_bus_model
`default_nettype wire

//--- display_cmd_protect_config_tb.sv
/*
  Testbench for display_cmd_protect_config: reset values, settings, dividers, pixels, protection, standby.
  Assumes host_bus_model drives the command bus; other inputs driven here on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module display_cmd_protect_config_tb;
  import display_cfg_pkg::*;
  logic clock, arst_n, chip_select_n, data_command_select, write_strobe_n, bus_is_16bit_or_serial, standby_exit;
  logic window_restart, frame_start, pixel_in_valid, pixel_out_valid, standby_request, logic_supply_off;
  logic config_valid, write_wrap_enable, bus_data_format, bus_data_format_active, cmd_rejected, tear_signal;
  logic rgb_frame_write_en;
  logic [7:0] bus_data;
  logic [8:0] window_col_start, window_col_end, window_page_start, window_page_end, pixel_col, pixel_page, col5, page5;
  logic [15:0] pixel_in;
  logic [17:0] pixel_out, pix3;
  logic [1:0] cmd_protect_level, color_expand_format;
  logic [2:0] tear_interval, rgb_write_cycle;
  int mismatches, checked, rej_n, tear_n, pix_n, rgb_n;
  // only legal tear codes and expansion codes 00..10 are ever programmed
  logic [2:0] tcode[4] = '{3'h0, 3'h1, 3'h3, 3'h5};
  int tper[4] = '{1, 2, 4, 6};
  logic [15:0] pix[6] = '{16'hffff, 16'h0000, 16'h8410, 16'h7bef, 16'h0821, 16'hf81f};
  host_bus_model u_host (.*);
  display_cmd_protect_config u_dut (.*);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // pulse counters; the fifth pixel address is kept for the wrap test
  always @(posedge clock) begin
    if (cmd_rejected === 1'b1) rej_n++;
    if (tear_signal === 1'b1) tear_n++;
    if (pixel_out_valid === 1'b1) begin
      pix_n++;
      if (pix_n == 3) pix3 = pixel_out;
      if (pix_n == 5) begin
        col5 = pixel_col;
        page5 = pixel_page;
      end
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge clock) frame_start = 1'b1;
      @(negedge clock) frame_start = 1'b0;
      if (rgb_frame_write_en === 1'b1) rgb_n++;
    end
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    finish_test;
  end
  // =====================================================================
  // main sequence
  initial begin
    {arst_n, bus_is_16bit_or_serial, standby_exit, window_restart, frame_start, pixel_in_valid} = 6'h00;
    {window_col_start, window_col_end, window_page_start, window_page_end} = {9'h2, 9'h3, 9'h5, 9'h6};
    pixel_in = 16'h0000;
    repeat (12) @(posedge clock);
    @(negedge clock) arst_n = 1'b1;
    check("level", cmd_protect_level, 0);
    check("standby", {logic_supply_off, standby_request, config_valid}, 3'b001);
    check("b3 reset", {write_wrap_enable, tear_interval, rgb_write_cycle, color_expand_format, bus_data_format}, 0);
    u_host.write_cmd(CMD_FMEM_IF, 32'h02030721, 4);
    check("b3 fields", {write_wrap_enable, tear_interval, rgb_write_cycle, color_expand_format, bus_data_format},
      {1'b1, 3'h3, 3'h7, 2'h2, 1'b1});
    for (int s = 1; s >= 0; s--) begin
      bus_is_16bit_or_serial = s[0];
      @(negedge clock);
      check("format active", bus_data_format_active, s);
    end
    $display("test settings done");
    for (int i = 0; i < 8; i++) begin
      u_host.write_cmd(CMD_FMEM_IF, {13'h0, tcode[i%4], 5'h0, i[2:0], 8'h00}, 4);
      frames(8);
      tear_n = 0;
      rgb_n = 0;
      frames(840);
      check("tear count", tear_n, 840 / tper[i%4]);
      check("rgb count", rgb_n, 840 / (i + 1));
    end
    $display("test frames done");
    for (int k = 0; k < 6; k++) begin
      u_host.write_cmd(CMD_FMEM_IF, {6'h0, k >= 3, 19'h0, k % 3 == 2, k % 3 == 1, 4'h0}, 4);
      @(negedge clock) window_restart = 1'b1;
      @(negedge clock) window_restart = 1'b0;
      pix_n = 0;
      for (int j = 0; j < 6; j++) begin
        pixel_in_valid = 1'b1;
        pixel_in = pix[j];
        @(negedge clock);
      end
      pixel_in_valid = 1'b0;
      repeat (2) @(negedge clock);
      check("pixel count", pix_n, k >= 3 ? 6 : 4);
      check("expand", pix3, k % 3 == 0 ? {6'h20, 6'h20, 6'h20} : {6'h21, 6'h20, 6'h21});
      if (k >= 3) check("wrap addr", {col5, page5}, {9'h2, 9'h5});
    end
    $display("test pixels done");
    for (int lv = 0; lv < 4; lv++) begin
      u_host.write_cmd(CMD_PROTECT, {6'h0, lv[1:0], 24'h0}, 1);
      check("level", cmd_protect_level, lv);
      rej_n = 0;
      u_host.write_cmd(8'hf0, 32'h0, 0);
      u_host.write_cmd(8'he0, 32'h0, 0);
      u_host.write_cmd(8'haf, 32'h0, 0);
      u_host.write_cmd(CMD_FMEM_IF, {21'h0, 1'b1, lv[1:0], 8'h00}, 4);
      @(negedge clock);
      check("rejects", rej_n, (lv >= 1) + (lv >= 2) + (lv == 3));
      check("rgb kept", rgb_write_cycle, lv == 3 ? 3'h6 : {1'b1, lv[1:0]});
    end
    u_host.write_cmd(CMD_PROTECT, 32'h0, 1);
    check("level open", cmd_protect_level, 0);
    $display("test protection done");
    u_host.write_cmd(CMD_STANDBY, 32'h01000000, 1);
    // config_valid drops one cycle after the request register rises
    @(negedge clock);
    check("standby on", {logic_supply_off, standby_request, config_valid}, 3'b110);
    u_host.write_cmd(CMD_FMEM_IF, 32'h00000500, 4);
    check("b3 in standby", {rgb_write_cycle, config_valid}, 4'ha);
    @(negedge clock) standby_exit = 1'b1;
    @(negedge clock) standby_exit = 1'b0;
    @(negedge clock);
    check("standby off", {standby_request, config_valid}, 0);
    u_host.write_cmd(CMD_FMEM_IF, 32'h0, 4);
    check("valid again", config_valid, 1);
    // standby first: at level 3 the standby command itself would be blocked
    u_host.write_cmd(CMD_STANDBY, 32'h01000000, 1);
    u_host.write_cmd(CMD_PROTECT, 32'h03000000, 1);
    check("before reset", {cmd_protect_level, standby_request}, 3'h7);
    @(negedge clock) arst_n = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    check("after reset", {cmd_protect_level, standby_request}, 0);
    $display("test standby done");
    finish_test;
  end
endmodule // display_cmd_protect_config_tb
`default_nettype wire
